// ===== common/iocs_pkg.sv
// Constants for the internal oscillator tuning and clock select block.
// Assumes a 20 MHz pclk; oscillators are modelled as phase accumulators.
package iocs_pkg;
   localparam longint unsigned CLK_HZ = 64'd20000000;
   localparam longint unsigned BASE_HZ = 64'd500000;
   localparam longint unsigned LF_HZ = 64'd31000;
   localparam longint unsigned RC_HZ = 64'd600000;
   localparam int NCO_W = 24;
   // High-frequency source is 32 times the base
   localparam int HF_SHIFT = 5;
   localparam logic [23:0] MF_INC = 24'((BASE_HZ << NCO_W) / CLK_HZ);
   localparam logic [23:0] LF_INC = 24'((LF_HZ << NCO_W) / CLK_HZ);
   localparam logic [23:0] RC_INC = 24'((RC_HZ << NCO_W) / CLK_HZ);
   localparam logic [23:0] TUNE_STEP = 24'(MF_INC >> 9);
   // Tuning value moves one step per slew interval
   localparam longint unsigned TUNE_SLEW_NS = 64'd1000;
   localparam logic [7:0] TUNE_SLEW_CYC = 8'((TUNE_SLEW_NS * CLK_HZ) / 64'd1000000000);
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TUNE = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_CFG = 8'h0C;
   localparam int CTRL_SCS_LSB = 0;
   localparam int CTRL_PLL_BIT = 2;
   localparam int CTRL_FREQ_LSB = 3;
   localparam int STAT_LF_RDY_BIT = 0;
   localparam int STAT_RC_RUN_BIT = 1;
   localparam int STAT_PLL_BIT = 2;
   localparam int STAT_PEND_BIT = 3;
   localparam logic [3:0] FREQ_RST = 4'h7;
   localparam logic [1:0] SCS_RST = 2'h0;
   localparam logic [5:0] TUNE_RST = 6'h00;
   localparam logic [1:0] CFG_RST = 2'h3;
   localparam logic [1:0] CFG_LF_ON = 2'h0;
   localparam logic [2:0] FREQ_LF_TOP = 3'h0;
   localparam logic [3:0] FREQ_PLL_CODE = 4'hE;
   localparam logic [5:0] TUNE_MAX = 6'h1F;
   localparam logic [5:0] TUNE_MIN = 6'h20;
   typedef enum logic [2:0] {SRC_LF = 3'b001, SRC_MF = 3'b010, SRC_HF = 3'b100} iocs_src_t;
   typedef enum logic [1:0] {SW_RUN = 2'b01, SW_WAIT = 2'b10} iocs_sw_t;
   // Source for each frequency select code
   function automatic iocs_src_t iocs_src_of(input logic [3:0] code);
      if (code[3:1] == FREQ_LF_TOP) return SRC_LF;
      if (code == 4'h3 || code[3]) return SRC_HF;
      return SRC_MF;
   endfunction : iocs_src_of
   // Postscaler as a power of two for each code
   function automatic logic [3:0] iocs_shift_of(input logic [3:0] code);
      case (code)
         4'h2: return 4'h4;
         4'h3: return 4'h9;
         4'h4: return 4'h3;
         4'h5: return 4'h2;
         4'h6: return 4'h1;
         4'h8: return 4'h7;
         4'h9: return 4'h6;
         4'hA: return 4'h5;
         4'hB: return 4'h4;
         4'hC: return 4'h3;
         4'hD: return 4'h2;
         4'hE: return 4'h1;
         default: return 4'h0;
      endcase
   endfunction : iocs_shift_of
endpackage : iocs_pkg

// ===== hw/iocs_top.sv
// Internal oscillator tuning, low-frequency/peripheral oscillator enables and
// glitch-free system clock select. Registers over APB; request pins are async.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - High and mid sources both come from the tuned 500 kHz base
// - Tuning value is 6-bit two's complement, zero after reset
// - Tuning 1Fh gives highest frequency, 20h gives lowest
// - Frequency slews toward a new tuning value, no completion status
// - Tuning never changes the low-frequency oscillator
// - Low-frequency oscillator is an untuned 31 kHz source for timers
// - Low oscillator runs on LF select with 1x source, config 00, or request
// - Ready flag sets after the first low oscillator tick, clears when it stops
// - Peripheral RC clock is an untuned nominal 600 kHz source
// - Peripheral RC clock starts on request without software enable
// - Peripheral RC clock keeps running during sleep
// - System clock picks postscaled high, mid or low oscillator by 4-bit field
// - 32 MHz exists only through the 4x PLL multiplier
// - Selectable rates 16 MHz down to 31.25 kHz, plus 31 kHz direct
// - Any reset loads select code 0111, giving 500 kHz
// - Several codes give one frequency through different sources
module iocs_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic periph_lf_request,
   input wire logic periph_rc_request,
   input wire logic sleep_req,
   output logic sys_clk_tick,
   output logic pll_mult_en,
   output logic hf_osc_tick,
   output logic mf_osc_tick,
   output logic lf_osc_tick,
   output logic lf_osc_enable,
   output logic periph_rc_tick
);
   logic [2:0] sync_meta;
   logic [2:0] sync_q;
   logic lf_req_s;
   logic rc_req_s;
   logic sleep_s;
   logic [3:0] freq_select_field;
   logic [1:0] sys_clk_source_select;
   logic pll_req;
   logic [5:0] osc_tune_value;
   logic [1:0] osc_config_select;
   logic [3:0] next_freq;
   logic [1:0] next_scs;
   logic next_pll_req;
   logic [5:0] next_tune;
   logic [1:0] next_cfg;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic setup;
   logic wr_en;
   logic [5:0] tune_eff;
   logic [7:0] slew_cnt;
   logic [5:0] next_tune_eff;
   logic [7:0] next_slew_cnt;
   logic [23:0] base_inc;
   logic [23:0] hf_inc;
   logic [23:0] mf_acc;
   logic [23:0] hf_acc;
   logic [23:0] lf_acc;
   logic [23:0] rc_acc;
   logic [24:0] mf_sum;
   logic [24:0] hf_sum;
   logic [24:0] lf_sum;
   logic [24:0] rc_sum;
   logic lf_need;
   logic low_osc_ready_flag;
   logic rc_run;
   logic next_lf_ready;
   iocs_pkg::iocs_sw_t sw_state;
   iocs_pkg::iocs_sw_t next_sw_state;
   logic [3:0] act_code;
   logic act_pll;
   logic [8:0] ps_cnt;
   logic [3:0] next_act_code;
   logic next_act_pll;
   logic [8:0] next_ps_cnt;
   iocs_pkg::iocs_src_t act_src;
   logic src_tick;
   logic [8:0] ps_mask;
   logic ps_tick;
   logic want_pll;
   logic pending;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_meta <= 3'h0;
         sync_q <= 3'h0;
      end else begin
         sync_meta <= {sleep_req, periph_rc_request, periph_lf_request};
         sync_q <= sync_meta;
      end
   end
   assign lf_req_s = sync_q[0];
   assign rc_req_s = sync_q[1];
   assign sleep_s = sync_q[2];

   // Register file, zero-wait APB slave
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite && !pslverr;
   always_comb begin
      next_freq = freq_select_field;
      next_scs = sys_clk_source_select;
      next_pll_req = pll_req;
      next_tune = osc_tune_value;
      next_cfg = osc_config_select;
      next_prdata = 32'h0000_0000;
      next_pready = setup;
      next_pslverr = 1'b0;
      if (wr_en) begin
         case (paddr)
            iocs_pkg::OFS_CTRL: begin
               next_freq = pwdata[iocs_pkg::CTRL_FREQ_LSB +: 4];
               next_scs = pwdata[iocs_pkg::CTRL_SCS_LSB +: 2];
               next_pll_req = pwdata[iocs_pkg::CTRL_PLL_BIT];
            end
            iocs_pkg::OFS_TUNE: next_tune = pwdata[5:0];
            iocs_pkg::OFS_CFG: next_cfg = pwdata[1:0];
            default: ;
         endcase
      end
      if (setup) begin
         case (paddr)
            iocs_pkg::OFS_CTRL: begin
               next_prdata[iocs_pkg::CTRL_FREQ_LSB +: 4] = freq_select_field;
               next_prdata[iocs_pkg::CTRL_PLL_BIT] = pll_req;
               next_prdata[iocs_pkg::CTRL_SCS_LSB +: 2] = sys_clk_source_select;
            end
            iocs_pkg::OFS_TUNE: next_prdata[5:0] = osc_tune_value;
            iocs_pkg::OFS_STAT: begin
               next_prdata[iocs_pkg::STAT_LF_RDY_BIT] = low_osc_ready_flag;
               next_prdata[iocs_pkg::STAT_RC_RUN_BIT] = rc_run;
               next_prdata[iocs_pkg::STAT_PLL_BIT] = pll_mult_en;
               next_prdata[iocs_pkg::STAT_PEND_BIT] = pending;
            end
            iocs_pkg::OFS_CFG: next_prdata[1:0] = osc_config_select;
            default: next_pslverr = 1'b1;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freq_select_field <= iocs_pkg::FREQ_RST;
         sys_clk_source_select <= iocs_pkg::SCS_RST;
         pll_req <= 1'b0;
         osc_tune_value <= iocs_pkg::TUNE_RST;
         osc_config_select <= iocs_pkg::CFG_RST;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         freq_select_field <= next_freq;
         sys_clk_source_select <= next_scs;
         pll_req <= next_pll_req;
         osc_tune_value <= next_tune;
         osc_config_select <= next_cfg;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // slew effective tuning one step at a time
   always_comb begin
      next_tune_eff = tune_eff;
      next_slew_cnt = slew_cnt;
      if (slew_cnt != 8'h00) begin
         next_slew_cnt = slew_cnt - 8'h01;
      end else if (tune_eff != osc_tune_value) begin
         next_slew_cnt = iocs_pkg::TUNE_SLEW_CYC - 8'h01;
         if ($signed(osc_tune_value) > $signed(tune_eff)) begin
            next_tune_eff = tune_eff + 6'h01;
         end else begin
            next_tune_eff = tune_eff - 6'h01;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tune_eff <= iocs_pkg::TUNE_RST;
         slew_cnt <= 8'h00;
      end else begin
         tune_eff <= next_tune_eff;
         slew_cnt <= next_slew_cnt;
      end
   end

   // signed tuning scales the base increment
   assign base_inc = iocs_pkg::MF_INC + ({{18{tune_eff[5]}}, tune_eff} * iocs_pkg::TUNE_STEP);
   // high source derived from the same tuned base
   assign hf_inc = base_inc << iocs_pkg::HF_SHIFT;
   assign mf_sum = {1'b0, mf_acc} + {1'b0, base_inc};
   assign hf_sum = {1'b0, hf_acc} + {1'b0, hf_inc};
   assign lf_sum = {1'b0, lf_acc} + {1'b0, iocs_pkg::LF_INC};
   assign rc_sum = {1'b0, rc_acc} + {1'b0, iocs_pkg::RC_INC};
   assign lf_need = ((freq_select_field[3:1] == iocs_pkg::FREQ_LF_TOP)
                     && sys_clk_source_select[1])
                    || (osc_config_select == iocs_pkg::CFG_LF_ON)
                    || lf_req_s || (act_src == iocs_pkg::SRC_LF);
   // ready once the running oscillator has ticked
   assign next_lf_ready = lf_osc_enable && (low_osc_ready_flag || lf_sum[24]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mf_acc <= 24'h00_0000;
         hf_acc <= 24'h00_0000;
         lf_acc <= 24'h00_0000;
         rc_acc <= 24'h00_0000;
         mf_osc_tick <= 1'b0;
         hf_osc_tick <= 1'b0;
         lf_osc_tick <= 1'b0;
         periph_rc_tick <= 1'b0;
         lf_osc_enable <= 1'b0;
         low_osc_ready_flag <= 1'b0;
         rc_run <= 1'b0;
      end else begin
         mf_acc <= mf_sum[23:0];
         hf_acc <= hf_sum[23:0];
         mf_osc_tick <= mf_sum[24];
         hf_osc_tick <= hf_sum[24];
         lf_acc <= lf_osc_enable ? lf_sum[23:0] : 24'h00_0000;
         lf_osc_tick <= lf_osc_enable && lf_sum[24];
         lf_osc_enable <= lf_need;
         low_osc_ready_flag <= next_lf_ready;
         // runs on request alone, sleep does not gate it
         rc_run <= rc_req_s;
         rc_acc <= rc_run ? rc_sum[23:0] : 24'h00_0000;
         periph_rc_tick <= rc_run && rc_sum[24];
      end
   end

   // source and postscaler of the active code
   assign act_src = iocs_pkg::iocs_src_of(act_code);
   assign ps_mask = 9'((10'h001 << iocs_pkg::iocs_shift_of(act_code)) - 10'h001);
   always_comb begin
      case (act_src)
         iocs_pkg::SRC_LF: src_tick = lf_osc_tick;
         iocs_pkg::SRC_MF: src_tick = mf_osc_tick;
         iocs_pkg::SRC_HF: src_tick = hf_osc_tick;
         default: src_tick = 1'b0;
      endcase
   end
   assign ps_tick = src_tick && ((ps_cnt & ps_mask) == ps_mask);
   // multiplier only on the 8 MHz high-source code
   assign want_pll = pll_req && (freq_select_field == iocs_pkg::FREQ_PLL_CODE);
   assign pending = (freq_select_field != act_code) || (want_pll != act_pll);
   // switch only at the end of a full output period
   always_comb begin
      next_sw_state = sw_state;
      next_act_code = act_code;
      next_act_pll = act_pll;
      next_ps_cnt = src_tick ? ps_cnt + 9'h001 : ps_cnt;
      case (sw_state)
         iocs_pkg::SW_RUN: begin
            if (pending) next_sw_state = iocs_pkg::SW_WAIT;
         end
         iocs_pkg::SW_WAIT: begin
            if (!pending) begin
               next_sw_state = iocs_pkg::SW_RUN;
            end else if (ps_tick) begin
               next_act_code = freq_select_field;
               next_act_pll = want_pll;
               next_ps_cnt = 9'h000;
               next_sw_state = iocs_pkg::SW_RUN;
            end
         end
         default: next_sw_state = iocs_pkg::SW_RUN;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_state <= iocs_pkg::SW_RUN;
         act_code <= iocs_pkg::FREQ_RST;
         act_pll <= 1'b0;
         ps_cnt <= 9'h000;
         sys_clk_tick <= 1'b0;
         pll_mult_en <= 1'b0;
      end else begin
         sw_state <= next_sw_state;
         act_code <= next_act_code;
         act_pll <= next_act_pll;
         ps_cnt <= next_ps_cnt;
         sys_clk_tick <= ps_tick && !sleep_s;
         pll_mult_en <= next_act_pll;
      end
   end

   // Gap counter between low oscillator ticks, held at zero while stopped
   // so the first period after enable counts from the same origin as the
   // accumulator
   logic [10:0] lf_gap;
   logic [10:0] next_lf_gap;
   always_comb begin
      if (!lf_osc_enable) begin
         next_lf_gap = 11'h000;
      end else if (lf_osc_tick) begin
         next_lf_gap = 11'h001;
      end else begin
         next_lf_gap = lf_gap + 11'h001;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf_gap <= 11'h000;
      end else begin
         lf_gap <= next_lf_gap;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_hf_follows_mf;
      mf_osc_tick |-> ##[0:2] hf_osc_tick;
   endproperty
   a_hf_follows_mf: assert property (p_hf_follows_mf) else $error("hf missing");
   property p_tune_rst;
      $rose(presetn) |-> osc_tune_value == 6'h00 && tune_eff == 6'h00;
   endproperty
   a_tune_rst: assert property (@(posedge pclk) p_tune_rst) else $error("tune reset");
   property p_tune_ends;
      ($signed(tune_eff) > $signed($past(tune_eff))) |-> base_inc > $past(base_inc);
   endproperty
   a_tune_ends: assert property (p_tune_ends) else $error("tune max");
   property p_slew;
      (tune_eff != $past(tune_eff)) |-> $past(slew_cnt) == 8'h00 && $past(tune_eff != osc_tune_value);
   endproperty
   a_slew: assert property (p_slew) else $error("tune slew");
   property p_lf_gap;
      (lf_osc_tick && lf_osc_enable && $past(lf_osc_enable, 2)) |-> lf_gap inside {[11'd2:11'd646]};
   endproperty
   a_lf_gap: assert property (p_lf_gap) else $error("lf period");
   property p_lf_en;
      (osc_config_select == 2'h0) |=> lf_osc_enable;
   endproperty
   a_lf_en: assert property (p_lf_en) else $error("lf enable");
   property p_lf_rdy;
      !lf_osc_enable |=> !low_osc_ready_flag;
   endproperty
   a_lf_rdy: assert property (p_lf_rdy) else $error("lf ready");
   property p_rc_sleep;
      (rc_req_s && rc_run) [*2] |-> ##[1:40] (periph_rc_tick || !rc_req_s);
   endproperty
   a_rc_sleep: assert property (p_rc_sleep) else $error("rc stalled");
   property p_pll;
      pll_mult_en |-> act_code == 4'hE;
   endproperty
   a_pll: assert property (p_pll) else $error("pll code");
   property p_switch;
      (act_code != $past(act_code)) |-> $past(ps_tick) && ps_cnt == 9'h000;
   endproperty
   a_switch: assert property (p_switch) else $error("switch glitch");
   c_switch: cover property (sw_state == iocs_pkg::SW_WAIT ##1 sw_state == iocs_pkg::SW_RUN);
   c_lf_rdy: cover property ($rose(low_osc_ready_flag));
   c_pll: cover property ($rose(pll_mult_en));
   c_tune_max: cover property (tune_eff == 6'h1F);
endmodule : iocs_top
`default_nettype wire

// ===== tb/iocs_top_bench.sv
// Self-checking bench for the oscillator tuning and clock select block.
// Assumes a 20 MHz pclk, the APB map of iocs_pkg and APB answers within 16 cycles.
`timescale 1ns/100ps
`default_nettype none
module iocs_top_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic periph_lf_request = 1'b0;
   logic periph_rc_request = 1'b0;
   logic sleep_req = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sys_clk_tick;
   logic pll_mult_en;
   logic hf_osc_tick;
   logic mf_osc_tick;
   logic lf_osc_tick;
   logic lf_osc_enable;
   logic periph_rc_tick;
   int n_mismatch = 0;
   int n_tests = 0;
   int cs;
   int ch;
   int cm;
   int cl;
   int cr;
   logic [31:0] rdv;
   logic errv;
   // System ticks per 3200 cycles for each select code
   int exp_tab [16] = '{5, 5, 5, 5, 10, 20, 40, 80, 20, 40, 80, 160, 320, 640, 1280, 2560};

   always #25 pclk = ~pclk;

   iocs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .periph_lf_request(periph_lf_request),
      .periph_rc_request(periph_rc_request), .sleep_req(sleep_req),
      .sys_clk_tick(sys_clk_tick), .pll_mult_en(pll_mult_en), .hf_osc_tick(hf_osc_tick),
      .mf_osc_tick(mf_osc_tick), .lf_osc_tick(lf_osc_tick), .lf_osc_enable(lf_osc_enable),
      .periph_rc_tick(periph_rc_tick));

   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Rate counts pass if within a small tolerance of the expected figure
   function automatic logic [31:0] near(input int s, input int e);
      int tol;
      tol = e / 256 + 2;
      return (s >= e - tol && s <= e + tol) ? e : s;
   endfunction : near

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         n_mismatch++;
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h00000000);
      chk(nm, rdv, exp);
   endtask : rd

   task automatic win(input int cyc);
      cs = 0;
      ch = 0;
      cm = 0;
      cl = 0;
      cr = 0;
      repeat (cyc) begin
         @(posedge pclk);
         cs += (sys_clk_tick === 1'b1);
         ch += (hf_osc_tick === 1'b1);
         cm += (mf_osc_tick === 1'b1);
         cl += (lf_osc_tick === 1'b1);
         cr += (periph_rc_tick === 1'b1);
      end
   endtask : win

   // Poll the pending flag until the source switch lands
   task automatic wait_sw();
      int n;
      n = 0;
      do begin
         apb(1'b0, iocs_pkg::OFS_STAT, 32'h00000000);
         n++;
      end while (rdv[iocs_pkg::STAT_PEND_BIT] !== 1'b0 && n < 700);
      chk("switch_done", {31'h0, rdv[iocs_pkg::STAT_PEND_BIT]}, 32'h00000000);
   endtask : wait_sw

   initial begin
      repeat (98000) @(posedge pclk);
      n_mismatch++;
      stop_test();
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(iocs_pkg::OFS_CTRL, {25'h0, iocs_pkg::FREQ_RST, 3'h0}, "ctrl_rst");
      rd(iocs_pkg::OFS_TUNE, 32'h00000000, "tune_rst");
      rd(iocs_pkg::OFS_CFG, 32'h00000003, "cfg_rst");
      rd(iocs_pkg::OFS_STAT, 32'h00000000, "stat_rst");
      apb(1'b0, 8'h10, 32'h00000000);
      chk("unmapped_err", {31'h0, errv}, 32'h00000001);
      chk("unmapped_data", rdv, 32'h00000000);
      apb(1'b1, iocs_pkg::OFS_STAT, 32'h0000000F);
      rd(iocs_pkg::OFS_STAT, 32'h00000000, "stat_readonly");
      // Tuning extremes move high and mid sources together, low stays put
      apb(1'b1, iocs_pkg::OFS_CFG, 32'h00000000);
      apb(1'b1, iocs_pkg::OFS_TUNE, 32'hFFFFFFDF);
      rd(iocs_pkg::OFS_TUNE, 32'h0000001F, "tune_max");
      win(1400);
      rd(iocs_pkg::OFS_STAT, 32'h00000001, "lf_ready");
      chk("lf_enable_cfg", {31'h0, lf_osc_enable}, 32'h00000001);
      win(3200);
      chk("mf_tune_max", near(cm, 85), 85);
      chk("hf_tune_max", near(ch, 2715), 2715);
      chk("sys_tune_max", near(cs, 85), 85);
      chk("lf_tune_max", near(cl, 5), 5);
      apb(1'b1, iocs_pkg::OFS_TUNE, 32'h00000020);
      rd(iocs_pkg::OFS_TUNE, 32'h00000020, "tune_min");
      win(1400);
      win(3200);
      chk("mf_tune_min", near(cm, 75), 75);
      chk("hf_tune_min", near(ch, 2400), 2400);
      chk("lf_tune_min", near(cl, 5), 5);
      apb(1'b1, iocs_pkg::OFS_TUNE, 32'h00000000);
      apb(1'b1, iocs_pkg::OFS_CFG, 32'h00000003);
      win(1400);
      chk("lf_enable_off", {31'h0, lf_osc_enable}, 32'h00000000);
      rd(iocs_pkg::OFS_STAT, 32'h00000000, "lf_ready_off");
      periph_lf_request <= 1'b1;
      win(6);
      chk("lf_enable_req", {31'h0, lf_osc_enable}, 32'h00000001);
      periph_lf_request <= 1'b0;
      win(6);
      chk("lf_enable_unreq", {31'h0, lf_osc_enable}, 32'h00000000);
      apb(1'b1, iocs_pkg::OFS_CTRL, 32'h00000002);
      win(6);
      chk("lf_enable_sel", {31'h0, lf_osc_enable}, 32'h00000001);
      // Every select code, measured as ticks per window
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, iocs_pkg::OFS_CTRL, 32'(c) << 3);
         wait_sw();
         win(3200);
         chk("sys_rate", near(cs, exp_tab[c]), exp_tab[c]);
      end
      apb(1'b1, iocs_pkg::OFS_CTRL, 32'h00000074);
      wait_sw();
      win(2);
      chk("pll_on", {31'h0, pll_mult_en}, 32'h00000001);
      rd(iocs_pkg::OFS_STAT, 32'h00000004, "pll_stat");
      apb(1'b1, iocs_pkg::OFS_CTRL, 32'h0000007C);
      wait_sw();
      win(2);
      chk("pll_other_code", {31'h0, pll_mult_en}, 32'h00000000);
      // Peripheral RC clock: off without request, on with it, through sleep
      apb(1'b1, iocs_pkg::OFS_CTRL, 32'h00000038);
      wait_sw();
      win(200);
      chk("rc_idle", 32'(cr), 32'h00000000);
      periph_rc_request <= 1'b1;
      sleep_req <= 1'b1;
      win(6);
      win(3200);
      chk("rc_rate_sleep", near(cr, 96), 96);
      chk("sys_sleep", 32'(cs), 32'h00000000);
      rd(iocs_pkg::OFS_STAT, 32'h00000002, "rc_stat");
      periph_rc_request <= 1'b0;
      sleep_req <= 1'b0;
      // Reset in mid-run returns to the default selection
      apb(1'b1, iocs_pkg::OFS_CTRL, 32'h00000078);
      apb(1'b1, iocs_pkg::OFS_TUNE, 32'h00000005);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(iocs_pkg::OFS_CTRL, 32'h00000038, "ctrl_rerst");
      rd(iocs_pkg::OFS_TUNE, 32'h00000000, "tune_rerst");
      win(3200);
      chk("sys_rerst", near(cs, 80), 80);
      stop_test();
   end
endmodule : iocs_top_bench
`default_nettype wire
